//--- verilog/fnvb_map.vh
// Register offsets, field positions, reset values and timing counts of the nv-bit command unit
`ifndef FNVB_MAP_VH
`define FNVB_MAP_VH
`define FNVB_OFF_MODE 8'h00
`define FNVB_OFF_CMD 8'h04
`define FNVB_OFF_STAT 8'h08
`define FNVB_OFF_RES 8'h0c
`define FNVB_MODE_RST 32'h0000_0000
`define FNVB_STAT_RST 32'h0000_0001
`define FNVB_RES_RST 32'h0000_0000
`define FNVB_KEY_HI 31
`define FNVB_KEY_LO 24
`define FNVB_ARG_HI 23
`define FNVB_ARG_LO 8
`define FNVB_CODE_HI 7
`define FNVB_CODE_LO 0
`define FNVB_WS_HI 11
`define FNVB_WS_LO 8
`define FNVB_RDY_IE_BIT 0
`define FNVB_RDY_BIT 0
`define FNVB_CMDE_BIT 1
`define FNVB_LOCKE_BIT 2
`define FNVB_KEY_VALUE 8'h5a
`define FNVB_CODE_SET 8'h0b
`define FNVB_CODE_CLEAR 8'h0c
`define FNVB_CODE_GET 8'h0d
`define FNVB_NUM_BITS 3
`define FNVB_NV_BUSY_CYCLES 4'h8
`endif

//--- verilog/fnvb_flash_nv_bit_command_unit.v
// Command, status and result registers for the general nonvolatile configuration bits
// Functional notes
// - Keyed set-bit command with index in argument sets that nonvolatile bit.
// - Set or clear with out-of-range index does nothing to any bit.
// - Keyed clear-bit command with index in argument clears that nonvolatile bit.
// - Get-bits ignores argument; result reads give 32 bits each, then zero.
// - Command completion sets ready; interrupt only when ready enable is one.
// - Ready reads zero while busy, one when idle; cleared when busy.
// - Command-error flag set on bad code or key; cleared by status read or command write.
// - Lock-error flag set on locked program/erase; cleared by status read or command write.
// - Command executes only with key 0x5A; otherwise nothing starts.
// - Argument is bit index for bit commands, don't-care for get.
// - Each flash access lasts wait-state count plus one cycles.
// - Flash reads keep being served during configuration-bit commands.
// - Configuration-bit commands never raise the lock-error flag.
// - Security enabled blocks debug and fast-programming flash access.
// - Configuration bit 0 is the security enable.
// - Security cleared by erase pin high plus completed full erase, or by a clear-bit command with index 0.
// - Configuration bits are separate from the main flash array.
// - Results wider than 32 bits come out 32 bits per successive read.
// - Ready clears as soon as a valid command starts.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "fnvb_map.vh"
module fnvb_flash_nv_bit_command_unit (
    input wire clk_in,
    input wire rstn_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire flash_rd_req_in,
    output reg flash_rd_ack_out,
    input wire lock_violation_in,
    input wire erase_pin_in,
    input wire full_erase_done_in,
    input wire dbg_flash_req_in,
    input wire fpi_flash_req_in,
    output wire dbg_flash_grant_out,
    output wire fpi_flash_grant_out,
    output reg [`FNVB_NUM_BITS-1:0] nv_bits_out,
    output reg irq_out
);
    localparam ST_IDLE = 3'b001;
    localparam ST_BUSY = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [31:0] mode_r;
    reg ready_r;
    reg cmd_err_r;
    reg lock_err_r;
    reg [`FNVB_NUM_BITS-1:0] nv_r;
    reg [`FNVB_NUM_BITS-1:0] snap_r;
    reg [7:0] op_code_r;
    reg [15:0] op_arg_r;
    reg [3:0] busy_cnt_r;
    reg [15:0] res_idx_r;
    reg [31:0] prdata_r;
    reg [3:0] ws_cnt_r;
    reg rd_active_r;
    reg erase_s1_r;
    reg erase_s2_r;
    reg lockv_s1_r;
    reg lockv_s2_r;
    reg ferase_s1_r;
    reg ferase_s2_r;
    reg dbg_s1_r;
    reg dbg_s2_r;
    reg fpi_s1_r;
    reg fpi_s2_r;

    wire access = psel_in & penable_in;
    wire wr_cmd = access & pwrite_in & (paddr_in == `FNVB_OFF_CMD);
    wire wr_mode = access & pwrite_in & (paddr_in == `FNVB_OFF_MODE);
    wire rd_stat = access & ~pwrite_in & (paddr_in == `FNVB_OFF_STAT);
    wire rd_res = access & ~pwrite_in & (paddr_in == `FNVB_OFF_RES);
    wire [7:0] key = pwdata_in[`FNVB_KEY_HI:`FNVB_KEY_LO];
    wire [7:0] code = pwdata_in[`FNVB_CODE_HI:`FNVB_CODE_LO];
    wire key_ok = (key == `FNVB_KEY_VALUE);
    wire code_ok = (code == `FNVB_CODE_SET) | (code == `FNVB_CODE_CLEAR) |
                   (code == `FNVB_CODE_GET);
    wire cmd_start = wr_cmd & key_ok & code_ok & (state_r == ST_IDLE);
    wire cmd_bad = wr_cmd & ~(key_ok & code_ok);
    wire unmapped = (paddr_in != `FNVB_OFF_MODE) & (paddr_in != `FNVB_OFF_CMD) &
                    (paddr_in != `FNVB_OFF_STAT) & (paddr_in != `FNVB_OFF_RES);
    wire security_on = nv_r[0];
    wire [31:0] res_word = (res_idx_r == 16'h0000) ?
                           {{(32-`FNVB_NUM_BITS){1'b0}}, snap_r} : 32'h0000_0000;
    wire in_range = (op_arg_r < `FNVB_NUM_BITS);
    wire [1:0] idx = op_arg_r[1:0];

    assign pready_out = 1'b1;
    assign pslverr_out = access & unmapped;
    assign prdata_out = prdata_r;
    assign dbg_flash_grant_out = dbg_s2_r & ~security_on;
    assign fpi_flash_grant_out = fpi_s2_r & ~security_on;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_start) begin
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (busy_cnt_r == 4'h0) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Erase pin synchroniser
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            erase_s1_r <= 1'b0;
            erase_s2_r <= 1'b0;
        end else begin
            erase_s1_r <= erase_pin_in;
            erase_s2_r <= erase_s1_r;
        end
    end

    // Lock violation synchroniser
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lockv_s1_r <= 1'b0;
            lockv_s2_r <= 1'b0;
        end else begin
            lockv_s1_r <= lock_violation_in;
            lockv_s2_r <= lockv_s1_r;
        end
    end

    // Full erase done synchroniser
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ferase_s1_r <= 1'b0;
            ferase_s2_r <= 1'b0;
        end else begin
            ferase_s1_r <= full_erase_done_in;
            ferase_s2_r <= ferase_s1_r;
        end
    end

    // Debug request synchroniser
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dbg_s1_r <= 1'b0;
            dbg_s2_r <= 1'b0;
        end else begin
            dbg_s1_r <= dbg_flash_req_in;
            dbg_s2_r <= dbg_s1_r;
        end
    end

    // Fast programming request synchroniser
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fpi_s1_r <= 1'b0;
            fpi_s2_r <= 1'b0;
        end else begin
            fpi_s1_r <= fpi_flash_req_in;
            fpi_s2_r <= fpi_s1_r;
        end
    end

    // Commit happens on the last busy cycle
    wire commit = (state_r == ST_BUSY) && (busy_cnt_r == 4'h0);
    wire do_set = commit && (op_code_r == `FNVB_CODE_SET);
    wire do_clear = commit && (op_code_r == `FNVB_CODE_CLEAR);
    wire do_get = commit && (op_code_r == `FNVB_CODE_GET);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Mode register
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_r <= `FNVB_MODE_RST;
        end else if (wr_mode) begin
            mode_r <= {20'h0_0000, pwdata_in[`FNVB_WS_HI:`FNVB_WS_LO], 7'h00,
                       pwdata_in[`FNVB_RDY_IE_BIT]};
        end
    end

    // Operands are captured only when a command really starts
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            op_code_r <= 8'h00;
        end else if (cmd_start) begin
            op_code_r <= code;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            op_arg_r <= 16'h0000;
        end else if (cmd_start) begin
            op_arg_r <= pwdata_in[`FNVB_ARG_HI:`FNVB_ARG_LO];
        end
    end

    // Busy time counter
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_cnt_r <= 4'h0;
        end else if (cmd_start) begin
            busy_cnt_r <= `FNVB_NV_BUSY_CYCLES;
        end else if (state_r == ST_BUSY && busy_cnt_r != 4'h0) begin
            busy_cnt_r <= busy_cnt_r - 4'h1;
        end
    end

    // Ready drops on the start edge and rises one cycle after commit
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ready_r <= 1'b1;
        end else if (cmd_start) begin
            ready_r <= 1'b0;
        end else if (state_r == ST_DONE) begin
            ready_r <= 1'b1;
        end
    end

    // Error flags: a new event wins over the clearing access
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_err_r <= 1'b0;
        end else if (cmd_bad) begin
            cmd_err_r <= 1'b1;
        end else if (rd_stat | wr_cmd) begin
            cmd_err_r <= 1'b0;
        end
    end

    // Only the external program/erase path reports lock errors
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_err_r <= 1'b0;
        end else if (lockv_s2_r) begin
            lock_err_r <= 1'b1;
        end else if (rd_stat | wr_cmd) begin
            lock_err_r <= 1'b0;
        end
    end

    // One cell per configuration bit, kept apart from the main array
    genvar gi;
    generate
        for (gi = 0; gi < `FNVB_NUM_BITS; gi = gi + 1) begin : g_nv
            wire hit = in_range && (idx == gi);
            always @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    nv_r[gi] <= 1'b0;
                    nv_bits_out[gi] <= 1'b0;
                end else begin
                    nv_bits_out[gi] <= nv_r[gi];
                    if (do_set && hit) begin
                        nv_r[gi] <= 1'b1;
                    end else if (do_clear && hit) begin
                        nv_r[gi] <= 1'b0;
                    end else if (gi == 0 && !commit && erase_s2_r && ferase_s2_r) begin
                        nv_r[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Snapshot taken by the get command
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            snap_r <= {`FNVB_NUM_BITS{1'b0}};
        end else if (do_get) begin
            snap_r <= nv_r;
        end
    end

    // Result word index, restarted by each get
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            res_idx_r <= 16'h0000;
        end else if (do_get) begin
            res_idx_r <= 16'h0000;
        end else if (rd_res && res_idx_r != 16'hffff) begin
            res_idx_r <= res_idx_r + 16'h0001;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= ready_r & mode_r[`FNVB_RDY_IE_BIT];
        end
    end

    // Read data is chosen in the setup cycle and held through the access
    reg [31:0] prdata_nxt;
    always @* begin
        case (paddr_in)
            `FNVB_OFF_MODE: prdata_nxt = mode_r;
            `FNVB_OFF_STAT: prdata_nxt = {29'h0000_0000, lock_err_r, cmd_err_r, ready_r};
            `FNVB_OFF_RES: prdata_nxt = res_word;
            default: prdata_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel_in & ~penable_in & ~pwrite_in) begin
            prdata_r <= prdata_nxt;
        end
    end

    // Flash read port, independent of the command engine
    wire [3:0] ws_field = mode_r[`FNVB_WS_HI:`FNVB_WS_LO];
    wire rd_take = !rd_active_r && flash_rd_req_in;
    wire rd_last = rd_active_r && (ws_cnt_r == 4'h1);

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_active_r <= 1'b0;
        end else if (rd_take) begin
            rd_active_r <= (ws_field != 4'h0);
        end else if (rd_last) begin
            rd_active_r <= 1'b0;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ws_cnt_r <= 4'h0;
        end else if (rd_take) begin
            ws_cnt_r <= ws_field;
        end else if (rd_active_r && !rd_last) begin
            ws_cnt_r <= ws_cnt_r - 4'h1;
        end
    end

    // Acknowledge lands wait-state count plus one cycles after the request
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flash_rd_ack_out <= 1'b0;
        end else begin
            flash_rd_ack_out <= (rd_take && ws_field == 4'h0) || rd_last;
        end
    end
endmodule

//--- tb/fnvb_assertions.sv
// Port-level assertions for the nv-bit command unit
`timescale 1ns/1ps
module fnvb_checker (
    input wire clk_in,
    input wire rstn_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pslverr_out,
    input wire flash_rd_req_in,
    input wire flash_rd_ack_out,
    input wire dbg_flash_grant_out,
    input wire fpi_flash_grant_out,
    input wire [2:0] nv_bits_out,
    input wire irq_out
);
    reg ie_r;
    wire acc = psel_in && penable_in;
    wire [7:0] code = pwdata_in[7:0];
    wire cmd_ok = acc && pwrite_in && paddr_in == 8'h04 && pwdata_in[31:24] == 8'h5a
        && code >= 8'h0b && code <= 8'h0d;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ie_r <= 1'b0;
        end else if (acc && pwrite_in && paddr_in == 8'h00) begin
            ie_r <= pwdata_in[0];
        end
    end
    a_unmapped_err: assert property (acc && paddr_in >= 8'h10 |-> pslverr_out)
        else $error("no error on unmapped access");
    a_mapped_ok: assert property (acc && paddr_in <= 8'h0c && paddr_in[1:0] == 2'b00 |-> !pslverr_out)
        else $error("error on mapped access");
    a_irq_enable: assert property (irq_out |-> ie_r || $past(ie_r))
        else $error("interrupt while disabled");
    a_irq_busy: assert property (cmd_ok && ie_r |-> ##[1:3] !irq_out)
        else $error("ready interrupt not dropped on command");
    a_irq_done: assert property (cmd_ok && ie_r |-> ##[8:20] irq_out)
        else $error("ready interrupt missing after command");
    a_dbg_secure: assert property (dbg_flash_grant_out && $past(dbg_flash_grant_out)
        |-> !nv_bits_out[0]) else $error("debug access while secured");
    a_fpi_secure: assert property (fpi_flash_grant_out && $past(fpi_flash_grant_out)
        |-> !nv_bits_out[0]) else $error("fast access while secured");
    a_read_ack: assert property ($rose(flash_rd_req_in) |-> ##[1:17] flash_rd_ack_out)
        else $error("flash read not acknowledged");
endmodule
bind fnvb_flash_nv_bit_command_unit fnvb_checker u_chk (.*);

//--- tb/test_flash_nv_bit_command_unit.sv
// Directed testbench for the nv-bit command unit
`timescale 1ns/1ps
module test_flash_nv_bit_command_unit;
    reg clk, rstn, psel, pen, pwr, rreq, lkv, epin, edone, dreq, freq, perr_q;
    reg [7:0] paddr;
    reg [31:0] pwd, rd, n;
    wire [31:0] prd;
    wire prdy, perr, rack, dg, fg, irq;
    wire [2:0] nv;
    integer n_fail = 0;
    integer checks_done = 0;
    integer cyc = 0;
    fnvb_flash_nv_bit_command_unit u_dut (
        .clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .flash_rd_req_in(rreq), .flash_rd_ack_out(rack),
        .lock_violation_in(lkv), .erase_pin_in(epin), .full_erase_done_in(edone),
        .dbg_flash_req_in(dreq), .fpi_flash_req_in(freq), .dbg_flash_grant_out(dg),
        .fpi_flash_grant_out(fg), .nv_bits_out(nv), .irq_out(irq));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer; a spare edge first keeps transfers apart
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwr <= w;
            paddr <= a;
            pwd <= d;
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (prdy !== 1'b1) @(posedge clk);
            rd = prd;
            perr_q = perr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task wait_rdy;
        begin
            rd = 32'h0000_0000;
            while (rd[0] !== 1'b1) apb(1'b0, 8'h08, 32'h0000_0000);
        end
    endtask
    task t_regs;
        begin
            apb(1'b0, 8'h00, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd, 32'h0000_0001);
            apb(1'b0, 8'h0c, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            apb(1'b0, 8'h10, 32'h0000_0000);
            chk({perr_q, rd[30:0]}, 32'h8000_0000);
            apb(1'b1, 8'h00, 32'h0000_0201);
            apb(1'b0, 8'h00, 32'h0000_0000);
            chk(rd, 32'h0000_0201);
            $display("t_regs done");
        end
    endtask
    task t_set_get;
        begin
            apb(1'b1, 8'h04, 32'h5a00_010b);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            rreq <= 1'b1;
            n = 32'h0000_0000;
            while (rack !== 1'b1 && n < 32'h0000_0014) begin
                @(posedge clk);
                #1;
                n = n + 32'h0000_0001;
            end
            chk(n, 32'h0000_0003);
            @(posedge clk);
            rreq <= 1'b0;
            wait_rdy;
            chk({31'h0, irq}, 32'h0000_0001);
            chk({29'h0, nv}, 32'h0000_0002);
            apb(1'b1, 8'h04, 32'h5a00_030b);
            wait_rdy;
            chk({29'h0, nv}, 32'h0000_0002);
            apb(1'b1, 8'h04, 32'h5a12_340d);
            wait_rdy;
            apb(1'b0, 8'h0c, 32'h0000_0000);
            chk(rd, 32'h0000_0002);
            apb(1'b0, 8'h0c, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            $display("t_set_get done");
        end
    endtask
    task t_clear_err;
        begin
            apb(1'b1, 8'h04, 32'h5a00_010c);
            wait_rdy;
            chk({29'h0, nv}, 32'h0000_0000);
            apb(1'b1, 8'h04, 32'ha500_000b);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd, 32'h0000_0003);
            chk({29'h0, nv}, 32'h0000_0000);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd, 32'h0000_0001);
            lkv <= 1'b1;
            repeat (2) @(posedge clk);
            lkv <= 1'b0;
            repeat (3) @(posedge clk);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd, 32'h0000_0005);
            apb(1'b1, 8'h04, 32'h5a00_00ff);
            apb(1'b1, 8'h04, 32'h5a00_000d);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            wait_rdy;
            $display("t_clear_err done");
        end
    endtask
    task t_secure;
        begin
            chk({30'h0, dg, fg}, 32'h0000_0003);
            apb(1'b1, 8'h04, 32'h5a00_000b);
            wait_rdy;
            repeat (3) @(posedge clk);
            chk({29'h0, nv}, 32'h0000_0001);
            chk({30'h0, dg, fg}, 32'h0000_0000);
            epin <= 1'b1;
            repeat (6) @(posedge clk);
            chk({30'h0, dg, fg}, 32'h0000_0000);
            edone <= 1'b1;
            repeat (6) @(posedge clk);
            edone <= 1'b0;
            epin <= 1'b0;
            repeat (3) @(posedge clk);
            chk({29'h0, nv}, 32'h0000_0000);
            chk({30'h0, dg, fg}, 32'h0000_0003);
            $display("t_secure done");
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    initial begin
        {rstn, psel, pen, pwr, rreq, lkv, epin, edone, dreq, freq} = 10'h003;
        paddr = 8'h00;
        pwd = 32'h0000_0000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_set_get;
        t_clear_err;
        t_secure;
        stop_test;
    end
endmodule
